// ==== hw/asl_pkg.sv ====
/*
  package of the atomic swap data-port block: reply codes, fault codes, widths, byte enables.
  assumes one 100 MHz clock and a memory side answering with a two-bit reply code.
*/
package asl_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 30;
  localparam int unsigned REG_W = 5;
  localparam logic [1:0] REPLY_IDLE = 2'h0;
  localparam logic [1:0] REPLY_WAIT = 2'h1;
  localparam logic [1:0] REPLY_OK = 2'h2;
  localparam logic [1:0] REPLY_FAULT = 2'h3;
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_BUS = 2'h1;
  localparam logic [1:0] FAULT_PARITY = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 30'h0000_0000;
  localparam logic [REG_W-1:0] REG_ZERO = 5'h00;
  localparam logic [3:0] BE_ALL = 4'hf;
  localparam logic [3:0] BE_NONE = 4'h0;
endpackage

// ==== hw/asl_parity.sv ====
/*
  even parity checker for a read word with one parity bit per byte.
  assumes the memory side drives one parity bit per byte lane.
*/
`timescale 1ns/10ps
`default_nettype none
module asl_parity (
  input wire logic [asl_pkg::DATA_W-1:0] data,
  input wire logic [3:0] par,
  output logic bad
);
  function automatic logic byte_bad(input logic [7:0] b, input logic p);
    byte_bad = (^b) ^ p;
  endfunction

  wire logic [3:0] lane_bad;
  assign lane_bad[0] = byte_bad(data[7:0], par[0]);
  assign lane_bad[1] = byte_bad(data[15:8], par[1]);
  assign lane_bad[2] = byte_bad(data[23:16], par[2]);
  assign lane_bad[3] = byte_bad(data[31:24], par[3]);
  assign bad = |lane_bad;
endmodule
`default_nettype wire

// ==== hw/asl_swap.sv ====
/*
  data-port sequencer for the atomic register/memory exchange.
  assumes the memory side answers each access with a reply code and blocks
  other masters while the lock output is high; one clock, async reset.
*/
`timescale 1ns/10ps
`default_nettype none
module asl_swap (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [asl_pkg::ADDR_W-1:0] start_addr,
  input wire logic [asl_pkg::REG_W-1:0] start_reg,
  input wire logic [asl_pkg::DATA_W-1:0] reg_rd_data,
  output logic busy,
  output logic irq_block,
  output logic done,
  output logic [1:0] fault,
  output logic reg_wr_en,
  output logic [asl_pkg::REG_W-1:0] reg_wr_idx,
  output logic [asl_pkg::DATA_W-1:0] reg_wr_data,
  output logic mem_req,
  output logic mem_wr,
  output logic [3:0] mem_be,
  output logic [asl_pkg::ADDR_W-1:0] mem_addr,
  output logic [asl_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_wdata_oe,
  output logic bus_lock_out,
  input wire logic [1:0] data_reply_code,
  input wire logic [asl_pkg::DATA_W-1:0] mem_rdata,
  input wire logic [3:0] mem_rpar
);
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} asl_state_e;

  // true while an access of the exchange is on the bus
  function automatic logic in_access(input asl_state_e s);
    in_access = (s == ST_READ) || (s == ST_WRITE);
  endfunction

  // reply that ends an access, success or fault
  function automatic logic reply_final(input logic [1:0] code);
    reply_final = (code == asl_pkg::REPLY_OK) || (code == asl_pkg::REPLY_FAULT);
  endfunction

  asl_state_e state_ff;
  asl_state_e nxt_state;
  logic [asl_pkg::ADDR_W-1:0] addr_ff;
  logic [asl_pkg::REG_W-1:0] idx_ff;
  logic [asl_pkg::DATA_W-1:0] temp_ff;
  logic [asl_pkg::DATA_W-1:0] nxt_temp;
  logic [asl_pkg::DATA_W-1:0] rdata_ff;
  logic [asl_pkg::DATA_W-1:0] nxt_rdata;
  logic [asl_pkg::DATA_W-1:0] wdata_ff;
  logic done_ff;
  logic wr_en_ff;
  logic oe_ff;
  logic [1:0] fault_ff;
  logic [1:0] nxt_fault;

  wire logic par_bad;
  asl_parity u_par (
    .data(mem_rdata),
    .par(mem_rpar),
    .bad(par_bad)
  );

  wire logic st_idle = (state_ff == ST_IDLE);
  wire logic st_read = (state_ff == ST_READ);
  wire logic st_write = (state_ff == ST_WRITE);
  wire logic active = in_access(state_ff);
  wire logic take = st_idle && start;
  wire logic reply_ok = (data_reply_code == asl_pkg::REPLY_OK);
  wire logic reply_fault = (data_reply_code == asl_pkg::REPLY_FAULT);
  wire logic rd_ok = st_read && reply_ok && !par_bad;
  wire logic rd_bad = st_read && (reply_fault || (reply_ok && par_bad));
  wire logic wr_end = st_write && reply_final(data_reply_code);
  wire logic wr_bad = wr_end && reply_fault;
  wire logic seq_end = rd_bad || wr_end;
  wire logic wr_good = wr_end && !wr_bad;
  wire logic [1:0] rd_fault_code = reply_fault ? asl_pkg::FAULT_BUS : asl_pkg::FAULT_PARITY;
  wire logic [1:0] wr_fault_code = wr_bad ? asl_pkg::FAULT_BUS : asl_pkg::FAULT_NONE;
  wire logic nxt_oe = (nxt_state == ST_WRITE);

  always_comb begin
    nxt_state = state_ff;
    nxt_temp = temp_ff;
    nxt_rdata = rdata_ff;
    nxt_fault = asl_pkg::FAULT_NONE;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_state = ST_READ;
          nxt_temp = reg_rd_data;
        end
      end
      ST_READ: begin
        if (rd_ok) begin
          nxt_state = ST_WRITE;
          nxt_rdata = mem_rdata;
        end else if (rd_bad) begin
          nxt_state = ST_IDLE;
          nxt_fault = rd_fault_code;
        end
      end
      ST_WRITE: begin
        if (wr_end) begin
          nxt_state = ST_IDLE;
          nxt_fault = wr_fault_code;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      addr_ff <= asl_pkg::ADDR_ZERO;
    end else begin
      if (take) begin
        addr_ff <= start_addr;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      idx_ff <= asl_pkg::REG_ZERO;
    end else begin
      if (take) begin
        idx_ff <= start_reg;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      temp_ff <= asl_pkg::DATA_ZERO;
    end else begin
      temp_ff <= nxt_temp;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= asl_pkg::DATA_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wdata_ff <= asl_pkg::DATA_ZERO;
    end else begin
      if (rd_ok) begin
        wdata_ff <= temp_ff;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= seq_end;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fault_ff <= asl_pkg::FAULT_NONE;
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_en_ff <= 1'b0;
    end else begin
      wr_en_ff <= wr_good;
    end
  end

  // write data driven for the whole write half, waits included
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= nxt_oe;
    end
  end

  assign busy = active;
  assign irq_block = active;
  assign bus_lock_out = active;
  assign mem_req = active;
  assign mem_wr = st_write;
  assign mem_be = active ? asl_pkg::BE_ALL : asl_pkg::BE_NONE;
  assign mem_addr = addr_ff;
  assign mem_wdata = wdata_ff;
  assign mem_wdata_oe = oe_ff;
  assign done = done_ff;
  assign fault = fault_ff;
  assign reg_wr_en = wr_en_ff;
  assign reg_wr_idx = idx_ff;
  assign reg_wr_data = rdata_ff;
endmodule
`default_nettype wire

// ==== sim/asl_swap_checker.sv ====
/* checker of the exchange sequencer: lock, write and completion timing.
   assumes it is bound to asl_swap. */
`timescale 1ns/10ps
`default_nettype none
module asl_swap_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic busy,
  input wire logic irq_block,
  input wire logic done,
  input wire logic [1:0] fault,
  input wire logic reg_wr_en,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic mem_wdata_oe,
  input wire logic bus_lock_out,
  input wire logic [1:0] data_reply_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire fin = data_reply_code[1];
  take_lock_a: assert property (start && !busy |=> bus_lock_out && !mem_wr)
    else $error("no locked read");
  irq_hold_a: assert property (busy |-> irq_block) else $error("irq open");
  lock_cover_a: assert property (mem_req |-> bus_lock_out) else $error("lock low");
  lock_rel_a: assert property (mem_wr && fin |=> !bus_lock_out && done)
    else $error("lock not released");
  wr_hold_a: assert property (mem_wr && !fin |=> mem_wr && bus_lock_out)
    else $error("lock dropped early");
  fault_wr_a: assert property (done |-> reg_wr_en == (fault == asl_pkg::FAULT_NONE))
    else $error("bad reg write");
  wdata_drive_a: assert property (mem_wdata_oe == mem_wr)
    else $error("write data drive wrong");
endmodule
bind asl_swap asl_swap_checker i_chk (.*);
`default_nettype wire

// ==== sim/asl_mem.sv ====
/* memory side model: one word, set wait count, injectable faults.
   assumes the bench sets word_ff, wait_n and mode_sel. */
`timescale 1ns/10ps
`default_nettype none
module asl_mem (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [31:0] mem_wdata,
  output logic [1:0] data_reply_code,
  output logic [31:0] mem_rdata,
  output logic [3:0] mem_rpar
);
  logic [31:0] word_ff = 32'h0;
  logic [3:0] cnt_ff;
  logic [3:0] wait_n = 4'h0;
  logic [1:0] mode_sel = 2'h0;
  wire ans = mem_req && cnt_ff == wait_n;
  wire bad = mem_wr ? mode_sel == 2'h3 : mode_sel == 2'h1;
  // sole master, always granted; code 01 while waiting, success code 10, injected bus fault code 11 (parity fault in mode 2 answers 10)
  assign data_reply_code = !mem_req ? 2'h0 : !ans ? 2'h1 : bad ? 2'h3 : 2'h2;
  assign mem_rdata = ans && !mem_wr ? word_ff : ~word_ff;
  assign mem_rpar = {^mem_rdata[31:24], ^mem_rdata[23:16], ^mem_rdata[15:8],
    ^mem_rdata[7:0] ^ (mode_sel == 2'h2)};
  always @(posedge clock) begin
    cnt_ff <= sys_rst || ans || !mem_req ? 4'h0 : cnt_ff + 4'h1;
    if (ans && mem_wr && !bad) word_ff <= mem_wdata;
  end
endmodule
`default_nettype wire

// ==== sim/asl_swap_test.sv ====
/* testbench of asl_swap: exchanges with waits and faults.
   assumes a 100 MHz clock, inputs changed at the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module asl_swap_test;
  logic clock = 1'b0, sys_rst = 1'b1, start = 1'b0;
  logic [4:0] start_reg = 5'h0, reg_wr_idx;
  logic [29:0] start_addr = 30'h0, mem_addr;
  logic [31:0] reg_rd_data = 32'h0, reg_wr_data, mem_wdata, mem_rdata;
  logic busy, irq_block, done, reg_wr_en, mem_req, mem_wr, mem_wdata_oe, bus_lock_out;
  logic [1:0] fault, data_reply_code;
  logic [3:0] mem_be, mem_rpar;
  int miscompares = 0, n_tests = 0;
  asl_swap i_dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(start),
    .start_addr(start_addr),
    .start_reg(start_reg),
    .reg_rd_data(reg_rd_data),
    .busy(busy),
    .irq_block(irq_block),
    .done(done),
    .fault(fault),
    .reg_wr_en(reg_wr_en),
    .reg_wr_idx(reg_wr_idx),
    .reg_wr_data(reg_wr_data),
    .mem_req(mem_req),
    .mem_wr(mem_wr),
    .mem_be(mem_be),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_wdata_oe(mem_wdata_oe),
    .bus_lock_out(bus_lock_out),
    .data_reply_code(data_reply_code),
    .mem_rdata(mem_rdata),
    .mem_rpar(mem_rpar)
  );
  asl_mem i_mem (
    .clock(clock),
    .sys_rst(sys_rst),
    .mem_req(mem_req),
    .mem_wr(mem_wr),
    .mem_wdata(mem_wdata),
    .data_reply_code(data_reply_code),
    .mem_rdata(mem_rdata),
    .mem_rpar(mem_rpar)
  );
  initial begin
    forever #5 clock = ~clock;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task swap(input logic [3:0] w, input logic [1:0] m, input logic [1:0] f);
    logic [31:0] mv;
    logic [4:0] r;
    int k;
    mv = 32'hc3c3_0f00 ^ w;
    r = 5'h1f - m;
    i_mem.word_ff = mv;
    i_mem.wait_n = w;
    i_mem.mode_sel = m;
    start_reg = r;
    start_addr = 30'h3fff_fff0 | w;
    reg_rd_data = ~mv;
    start = 1'b1;
    @(negedge clock);
    chk({busy, irq_block, bus_lock_out, mem_req, mem_wr}, 5'h1e);
    chk(mem_be, 4'hf);
    chk(mem_addr, 30'h3fff_fff0 | w);
    start_reg = ~r;
    reg_rd_data = mv;
    @(negedge clock);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      if (mem_wr === 1'b1) begin
        chk(mem_wdata_oe, 1'b1);
        chk(mem_wdata, ~mv);
        chk(bus_lock_out, 1'b1);
      end
      @(negedge clock);
      k++;
    end
    chk(k < 40, 1'b1);
    chk({busy, bus_lock_out, mem_req}, 3'h0);
    chk(fault, f);
    chk(reg_wr_en, m == 2'h0);
    chk(i_mem.word_ff, m == 2'h0 ? ~mv : mv);
    chk(reg_wr_idx, r);
    if (m == 2'h0) chk(reg_wr_data, mv);
  endtask
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    swap(4'h0, 2'h0, asl_pkg::FAULT_NONE);
    swap(4'h3, 2'h0, asl_pkg::FAULT_NONE);
    swap(4'h1, 2'h1, asl_pkg::FAULT_BUS);
    swap(4'h0, 2'h2, asl_pkg::FAULT_PARITY);
    swap(4'h2, 2'h3, asl_pkg::FAULT_BUS);
    swap(4'h0, 2'h0, asl_pkg::FAULT_NONE);
    finish_test;
  end
  initial begin
    #20000;
    miscompares++;
    finish_test;
  end
endmodule
`default_nettype wire
